// ### design/sleep_pkg.sv
// Constants, register map and types of the sleep control unit
package sleep_pkg;

	// Register byte offsets on the bus
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;

	// Field positions of sleep_control
	localparam int SEN_BIT = 0;
	localparam int MODE_LSB = 1;
	localparam int MODE_MSB = 2;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// Field positions of the status register
	localparam int STAT_ASLEEP_BIT = 0;
	localparam int STAT_MODE_LSB = 1;
	localparam int STAT_MODE_MSB = 2;
	localparam int STAT_WAKING_BIT = 3;
	localparam int STAT_BOD_BIT = 4;

	// Sleep mode encodings
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_STBY = 2'h1;
	localparam logic [1:0] MODE_POWER_DOWN_MODE = 2'h2;

	// Brown-out fuse value that holds wake-up until the detector is ready
	localparam logic [1:0] BOD_WAIT_CFG = 2'h3;

	// Wake-up delay in peripheral clock cycles
	localparam int WAKE_CYCLES = 6;
	localparam int WAKE_CNT_W = 3;
	localparam logic [WAKE_CNT_W-1:0] WAKE_LOAD = WAKE_CNT_W'(WAKE_CYCLES - 1);
	localparam logic [WAKE_CNT_W-1:0] WAKE_LAST = 3'h1;

	// Width of the asynchronous ready inputs that pass the synchroniser
	localparam int SYNC_W = 2;
	localparam logic [SYNC_W-1:0] SYNC_RST = 2'h0;

	typedef enum logic [2:0] {
		ST_ACTIVE,
		ST_IDLE,
		ST_STANDBY,
		ST_POWER_DOWN_MODE,
		ST_OSC_WAIT,
		ST_WAKE_CNT
	} slp_state_e;

endpackage : sleep_pkg

// ### design/ready_sync.sv
// Two-flop synchroniser for the asynchronous ready levels
`timescale 1ns/100ps
module ready_sync
	import sleep_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [SYNC_W-1:0] async_i,
	output logic [SYNC_W-1:0] sync_o
);

	typedef struct packed {
		logic [SYNC_W-1:0] stage1;
		logic [SYNC_W-1:0] stage2;
	} sync_s;

	sync_s q_r;
	sync_s q_nxt;

	// Only the second stage is looked at
	always_comb begin
		q_nxt = q_r;
		q_nxt.stage1 = async_i;
		q_nxt.stage2 = q_r.stage1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r <= '{stage1: SYNC_RST, stage2: SYNC_RST};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign sync_o = q_r.stage2;

endmodule : ready_sync

// ### design/wake_timer.sv
// Fixed wake-up delay counter
`timescale 1ns/100ps
module wake_timer
	import sleep_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	output logic done_o
);

	typedef struct packed {
		logic busy;
		logic done;
		logic [WAKE_CNT_W-1:0] cnt;
	} tmr_s;

	tmr_s q_r;
	tmr_s q_nxt;

	// Done rises five edges after the start edge and holds until the next start,
	// so a late brown-out ready can still finish the wake-up
	always_comb begin
		q_nxt = q_r;
		if (start_i) begin
			q_nxt.busy = 1'b1;
			q_nxt.done = 1'b0;
			q_nxt.cnt = WAKE_LOAD;
		end else if (q_r.busy) begin
			q_nxt.cnt = q_r.cnt - WAKE_CNT_W'(1);
			if (q_r.cnt == WAKE_LAST) begin
				q_nxt.busy = 1'b0;
				q_nxt.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r <= '{busy: 1'b0, done: 1'b0, cnt: '0};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign done_o = q_r.done;

endmodule : wake_timer

// ### design/sleep_ctl_unit.sv
// Sleep control unit: mode entry, clock domain gating and wake-up sequencing
`timescale 1ns/100ps
module sleep_ctl_unit
	import sleep_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sleep_instr_i,
	input wire logic debug_break_i,
	input wire logic global_irq_en_i,
	input wire logic irq_pin_i,
	input wire logic irq_twi_addr_i,
	input wire logic irq_sof_i,
	input wire logic irq_adc_win_i,
	input wire logic irq_rtc_i,
	input wire logic irq_capture_i,
	input wire logic irq_pit_i,
	input wire logic irq_other_i,
	input wire logic rtc_stby_i,
	input wire logic adc_stby_i,
	input wire logic usart_stby_i,
	input wire logic main_osc_stby_i,
	input wire logic rtc_osc_stby_i,
	input wire logic bod_uses_ulp_i,
	input wire logic wdt_uses_ulp_i,
	input wire logic [1:0] brownout_config_fuse_i,
	input wire logic bod_ready_i,
	input wire logic osc_ready_i,
	output logic cpu_clk_en_o,
	output logic per_clk_en_o,
	output logic rtc_clk_en_o,
	output logic adc_clk_en_o,
	output logic pit_clk_en_o,
	output logic wdt_clk_en_o,
	output logic main_osc_en_o,
	output logic rtc_osc_en_o,
	output logic ulp_osc_en_o,
	output logic core_halt_o,
	output logic wake_irq_o,
	output logic sleep_nop_o
);

	typedef struct packed {
		slp_state_e st;
		logic sleep_enable;
		logic [1:0] mode;
		logic [1:0] slept_mode;
		logic irq_wake;
		logic ack;
		logic [31:0] rdata;
		logic cpu_clk_en;
		logic per_clk_en;
		logic rtc_clk_en;
		logic adc_clk_en;
		logic pit_clk_en;
		logic wdt_clk_en;
		logic main_osc_en;
		logic rtc_osc_en;
		logic ulp_osc_en;
		logic core_halt;
		logic wake_irq;
		logic sleep_nop;
	} slp_regs_s;

	slp_regs_s q_r;
	slp_regs_s q_nxt;

	logic [SYNC_W-1:0] ready_async;
	logic [SYNC_W-1:0] ready_synced;
	logic bod_ready_s;
	logic osc_ready_s;
	logic timer_start;
	logic timer_done;

	// Reserved encodings never count as a sleep mode
	function automatic logic mode_valid(input logic [1:0] m);
		mode_valid = (m == MODE_IDLE) || (m == MODE_STBY) || (m == MODE_POWER_DOWN_MODE);
	endfunction : mode_valid

	function automatic logic is_asleep(input slp_state_e s);
		is_asleep = (s == ST_IDLE) || (s == ST_STANDBY) || (s == ST_POWER_DOWN_MODE);
	endfunction : is_asleep

	function automatic logic is_waking(input slp_state_e s);
		is_waking = (s == ST_OSC_WAIT) || (s == ST_WAKE_CNT);
	endfunction : is_waking

	// Oscillator and brown-out ready levels come from analog logic
	assign ready_async = {bod_ready_i, osc_ready_i};

	ready_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(ready_async),
		.sync_o(ready_synced)
	);

	assign bod_ready_s = ready_synced[1];
	assign osc_ready_s = ready_synced[0];

	wake_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(timer_start),
		.done_o(timer_done)
	);

	logic irq_any;
	logic irq_stby;
	logic irq_power_down_mode;
	logic irq_wake_now;
	logic dbg_wake_now;
	logic osc_was_off;
	logic bod_hold;
	logic bus_req;
	logic bus_wr;

	always_comb begin
		q_nxt = q_r;
		timer_start = 1'b0;
		q_nxt.wake_irq = 1'b0;
		q_nxt.sleep_nop = 1'b0;

		irq_any = irq_pin_i | irq_twi_addr_i | irq_sof_i | irq_adc_win_i | irq_rtc_i |
			irq_capture_i | irq_pit_i | irq_other_i;

		irq_stby = irq_pin_i | irq_twi_addr_i | irq_capture_i | irq_pit_i |
			(irq_sof_i & usart_stby_i) | (irq_adc_win_i & adc_stby_i) |
			(irq_rtc_i & rtc_stby_i);

		irq_power_down_mode = irq_pin_i | irq_twi_addr_i | irq_pit_i;

		irq_wake_now = 1'b0;
		if (global_irq_en_i) begin
			case (q_r.st)
				ST_IDLE: begin
					irq_wake_now = irq_any;
				end
				ST_STANDBY: begin
					irq_wake_now = irq_stby;
				end
				ST_POWER_DOWN_MODE: begin
					irq_wake_now = irq_power_down_mode;
				end
				default: begin
					irq_wake_now = 1'b0;
				end
			endcase
		end

		dbg_wake_now = debug_break_i & is_asleep(q_r.st);

		osc_was_off = 1'b0;
		case (q_r.slept_mode)
			MODE_STBY: begin
				osc_was_off = ~main_osc_stby_i;
			end
			MODE_POWER_DOWN_MODE: begin
				osc_was_off = 1'b1;
			end
			default: begin
				osc_was_off = 1'b0;
			end
		endcase

		bod_hold = (brownout_config_fuse_i == BOD_WAIT_CFG) && !bod_ready_s;

		case (q_r.st)
			ST_ACTIVE: begin
				if (sleep_instr_i) begin
					if (q_r.sleep_enable && mode_valid(q_r.mode)) begin
						q_nxt.slept_mode = q_r.mode;
						q_nxt.irq_wake = 1'b0;
						case (q_r.mode)
							MODE_STBY: begin
								q_nxt.st = ST_STANDBY;
							end
							MODE_POWER_DOWN_MODE: begin
								q_nxt.st = ST_POWER_DOWN_MODE;
							end
							default: begin
								q_nxt.st = ST_IDLE;
							end
						endcase
					end else begin
						q_nxt.sleep_nop = 1'b1;
					end
				end
			end
			ST_IDLE, ST_STANDBY, ST_POWER_DOWN_MODE: begin
				if (irq_wake_now || dbg_wake_now) begin
					q_nxt.irq_wake = irq_wake_now;
					if (osc_was_off) begin
						q_nxt.st = ST_OSC_WAIT;
					end else begin
						q_nxt.st = ST_WAKE_CNT;
						timer_start = 1'b1;
					end
				end
			end
			ST_OSC_WAIT: begin
				if (osc_ready_s) begin
					q_nxt.st = ST_WAKE_CNT;
					timer_start = 1'b1;
				end
			end
			ST_WAKE_CNT: begin
				if (timer_done && !bod_hold) begin
					q_nxt.st = ST_ACTIVE;
					q_nxt.wake_irq = q_r.irq_wake;
				end
			end
			default: begin
				q_nxt.st = ST_ACTIVE;
			end
		endcase

		// Gating follows the next state so the enables line up with it
		q_nxt.cpu_clk_en = (q_nxt.st == ST_ACTIVE);
		q_nxt.core_halt = (q_nxt.st != ST_ACTIVE);
		q_nxt.wdt_clk_en = 1'b1;
		q_nxt.pit_clk_en = 1'b1;
		case (q_nxt.st)
			ST_IDLE: begin
				q_nxt.per_clk_en = 1'b1;
				q_nxt.rtc_clk_en = 1'b1;
				q_nxt.adc_clk_en = 1'b1;
				q_nxt.main_osc_en = 1'b1;
				q_nxt.rtc_osc_en = 1'b1;
				q_nxt.ulp_osc_en = 1'b1;
			end
			ST_STANDBY: begin
				q_nxt.per_clk_en = 1'b0;
				q_nxt.rtc_clk_en = rtc_stby_i;
				q_nxt.adc_clk_en = adc_stby_i;
				q_nxt.main_osc_en = main_osc_stby_i;
				q_nxt.rtc_osc_en = rtc_osc_stby_i;
				q_nxt.ulp_osc_en = 1'b1;
			end
			ST_POWER_DOWN_MODE: begin
				q_nxt.per_clk_en = 1'b0;
				q_nxt.rtc_clk_en = 1'b0;
				q_nxt.adc_clk_en = 1'b0;
				q_nxt.main_osc_en = 1'b0;
				q_nxt.rtc_osc_en = bod_uses_ulp_i | wdt_uses_ulp_i;
				q_nxt.ulp_osc_en = bod_uses_ulp_i | wdt_uses_ulp_i;
			end
			ST_OSC_WAIT: begin
				// Domains stay off until the restarted source is stable
				q_nxt.per_clk_en = 1'b0;
				q_nxt.rtc_clk_en = 1'b0;
				q_nxt.adc_clk_en = 1'b0;
				q_nxt.main_osc_en = 1'b1;
				q_nxt.rtc_osc_en = 1'b1;
				q_nxt.ulp_osc_en = 1'b1;
			end
			default: begin
				q_nxt.per_clk_en = 1'b1;
				q_nxt.rtc_clk_en = 1'b1;
				q_nxt.adc_clk_en = 1'b1;
				q_nxt.main_osc_en = 1'b1;
				q_nxt.rtc_osc_en = 1'b1;
				q_nxt.ulp_osc_en = 1'b1;
			end
		endcase

		// Classic single-cycle slave: ack one cycle after the strobe, then drop
		bus_req = wb_cyc_i && wb_stb_i && !q_r.ack;
		bus_wr = bus_req && wb_we_i && wb_sel_i[0];
		q_nxt.ack = bus_req;
		if (bus_req) begin
			q_nxt.rdata = 32'h0000_0000;
			case (wb_adr_i)
				CTRL_OFS: begin
					q_nxt.rdata[SEN_BIT] = q_r.sleep_enable;
					q_nxt.rdata[MODE_MSB:MODE_LSB] = q_r.mode;
				end
				STAT_OFS: begin
					q_nxt.rdata[STAT_ASLEEP_BIT] = is_asleep(q_r.st);
					q_nxt.rdata[STAT_MODE_MSB:STAT_MODE_LSB] = q_r.slept_mode;
					q_nxt.rdata[STAT_WAKING_BIT] = is_waking(q_r.st);
					q_nxt.rdata[STAT_BOD_BIT] = bod_ready_s;
				end
				default: begin
					q_nxt.rdata = 32'h0000_0000;
				end
			endcase
		end
		if (bus_wr && (wb_adr_i == CTRL_OFS)) begin
			q_nxt.sleep_enable = wb_dat_i[SEN_BIT];
			q_nxt.mode = wb_dat_i[MODE_MSB:MODE_LSB];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r <= '{
				st: ST_ACTIVE,
				sleep_enable: CTRL_RST[SEN_BIT],
				mode: CTRL_RST[MODE_MSB:MODE_LSB],
				slept_mode: MODE_IDLE,
				irq_wake: 1'b0,
				ack: 1'b0,
				rdata: 32'h0000_0000,
				cpu_clk_en: 1'b1,
				per_clk_en: 1'b1,
				rtc_clk_en: 1'b1,
				adc_clk_en: 1'b1,
				pit_clk_en: 1'b1,
				wdt_clk_en: 1'b1,
				main_osc_en: 1'b1,
				rtc_osc_en: 1'b1,
				ulp_osc_en: 1'b1,
				core_halt: 1'b0,
				wake_irq: 1'b0,
				sleep_nop: 1'b0
			};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign wb_dat_o = q_r.rdata;
	assign wb_ack_o = q_r.ack;
	assign cpu_clk_en_o = q_r.cpu_clk_en;
	assign per_clk_en_o = q_r.per_clk_en;
	assign rtc_clk_en_o = q_r.rtc_clk_en;
	assign adc_clk_en_o = q_r.adc_clk_en;
	assign pit_clk_en_o = q_r.pit_clk_en;
	assign wdt_clk_en_o = q_r.wdt_clk_en;
	assign main_osc_en_o = q_r.main_osc_en;
	assign rtc_osc_en_o = q_r.rtc_osc_en;
	assign ulp_osc_en_o = q_r.ulp_osc_en;
	assign core_halt_o = q_r.core_halt;
	assign wake_irq_o = q_r.wake_irq;
	assign sleep_nop_o = q_r.sleep_nop;

endmodule : sleep_ctl_unit

// ### sim/core_model.sv
// Core, interrupt sources and main oscillator facing the sleep unit
`timescale 1ns/100ps
module core_model #(
	parameter int OSC_START = 3
) (
	input wire logic clk_i,
	input wire logic core_halt_i,
	input wire logic main_osc_en_i,
	output logic sleep_instr_o,
	output logic [7:0] irq_o,
	output logic osc_ready_o
);
	int age = 0;
	initial begin
		sleep_instr_o = 1'b0;
		irq_o = 8'h00;
	end
	always @(posedge clk_i) begin
		if (!core_halt_i)
			irq_o <= 8'h00;
		age <= main_osc_en_i ? age + 1 : 0;
	end
	// Ready drops at once when the oscillator is switched off
	assign osc_ready_o = main_osc_en_i && age >= OSC_START;
	task automatic sleep_cmd();
		@(posedge clk_i);
		sleep_instr_o <= 1'b1;
		@(posedge clk_i);
		sleep_instr_o <= 1'b0;
	endtask : sleep_cmd
	task automatic raise(input int i);
		@(posedge clk_i);
		irq_o[i] <= 1'b1;
	endtask : raise
endmodule : core_model

// ### sim/sleep_ctl_chk.sv
// Port-level assertions of the sleep control unit
`timescale 1ns/100ps
module sleep_ctl_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic sleep_instr_i,
	input wire logic debug_break_i,
	input wire logic cpu_clk_en_o,
	input wire logic per_clk_en_o,
	input wire logic pit_clk_en_o,
	input wire logic wdt_clk_en_o,
	input wire logic core_halt_o,
	input wire logic wake_irq_o,
	input wire logic sleep_nop_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	halt_tracks_a: assert property (core_halt_o == !cpu_clk_en_o)
		else $error("halt differs from cpu clock");
	ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	entry_cause_a: assert property ($rose(core_halt_o) |-> $past(sleep_instr_i))
		else $error("halt without sleep");
	nop_awake_a: assert property (sleep_nop_o |-> !core_halt_o && $past(sleep_instr_i))
		else $error("bad nop pulse");
	wdt_pit_on_a: assert property (wdt_clk_en_o && pit_clk_en_o)
		else $error("watchdog or timer stopped");
	per_off_halted_a: assert property (!per_clk_en_o |-> core_halt_o)
		else $error("peripherals off while running");
	wake_count_a: assert property ($fell(core_halt_o) |-> $past(core_halt_o, 6)
		&& $past(per_clk_en_o, 6))
		else $error("wake too short");
	debug_wake_a: assert property (core_halt_o && debug_break_i |-> ##[1:60] !core_halt_o)
		else $error("break did not wake");
	reset_exit_a: assert property ($fell(rst_i) |-> !core_halt_o && cpu_clk_en_o)
		else $error("asleep after reset");
	irq_pulse_a: assert property (wake_irq_o |-> $fell(core_halt_o) ##1 !wake_irq_o)
		else $error("bad wake pulse");
	cover property (wake_irq_o);
	cover property (sleep_nop_o);
	cover property (core_halt_o && debug_break_i);
endmodule : sleep_ctl_chk
bind sleep_ctl_unit sleep_ctl_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.sleep_instr_i, .debug_break_i, .cpu_clk_en_o, .per_clk_en_o, .pit_clk_en_o,
	.wdt_clk_en_o, .core_halt_o, .wake_irq_o, .sleep_nop_o);

// ### sim/sleep_ctl_unit_bench.sv
// Self-checking bench of the sleep control unit
`timescale 1ns/100ps
module sleep_ctl_unit_bench;
	import sleep_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, dbg = 1'b0, bod_rdy = 1'b1;
	logic gie = 1'b1;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, q;
	logic [4:0] stby = 5'h12;
	logic [1:0] uses = 2'h2, fuse = 2'h0;
	wire [31:0] rd;
	wire [8:0] gates;
	wire [7:0] irq;
	wire slp, osc_rdy, ack, halt, wirq, nop;
	int mismatches = 0, total_checks = 0, n;
	sleep_ctl_unit i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
		.sleep_instr_i(slp), .debug_break_i(dbg), .global_irq_en_i(gie),
		.irq_pin_i(irq[0]), .irq_twi_addr_i(irq[1]), .irq_sof_i(irq[2]),
		.irq_adc_win_i(irq[3]), .irq_rtc_i(irq[4]), .irq_capture_i(irq[5]),
		.irq_pit_i(irq[6]), .irq_other_i(irq[7]), .rtc_stby_i(stby[4]),
		.adc_stby_i(stby[3]), .usart_stby_i(stby[2]), .main_osc_stby_i(stby[1]),
		.rtc_osc_stby_i(stby[0]), .bod_uses_ulp_i(uses[1]), .wdt_uses_ulp_i(uses[0]),
		.brownout_config_fuse_i(fuse), .bod_ready_i(bod_rdy), .osc_ready_i(osc_rdy),
		.cpu_clk_en_o(gates[8]), .per_clk_en_o(gates[7]), .rtc_clk_en_o(gates[6]),
		.adc_clk_en_o(gates[5]), .pit_clk_en_o(gates[4]), .wdt_clk_en_o(gates[3]),
		.main_osc_en_o(gates[2]), .rtc_osc_en_o(gates[1]), .ulp_osc_en_o(gates[0]),
		.core_halt_o(halt), .wake_irq_o(wirq), .sleep_nop_o(nop));
	core_model i_core (.clk_i, .core_halt_i(halt), .main_osc_en_i(gates[2]),
		.sleep_instr_o(slp), .irq_o(irq), .osc_ready_o(osc_rdy));
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", s, exp, got);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
	endtask : bus
	// Pre-edge values are read, so the first awake cycle is seen one edge late
	task automatic wake(output int c);
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
		end while (halt !== 1'b0 && c < 200);
	endtask : wake
	task automatic nap(input logic [2:0] ctl, input logic [8:0] g, input logic p);
		bus(1'b1, CTRL_OFS, 32'(ctl), 4'h1);
		i_core.sleep_cmd();
		@(posedge clk_i);
		chk("nop", 32'(nop), 32'(p));
		chk("gating", 32'(gates), 32'(g));
	endtask : nap
	task automatic t_regs();
		bus(1'b0, CTRL_OFS, 32'h0, 4'h0);
		chk("ctrl reset", q, 32'(CTRL_RST));
		bus(1'b1, CTRL_OFS, 32'hff, 4'h1);
		bus(1'b1, CTRL_OFS, 32'h0, 4'h0);
		bus(1'b0, CTRL_OFS, 32'h0, 4'h0);
		chk("ctrl rw", q, 32'h7);
		bus(1'b0, 4'h8, 32'h0, 4'h0);
		chk("unmapped", q, 32'h0);
		$display("end regs");
	endtask : t_regs
	task automatic t_modes();
		logic [31:0] st_exp;
		st_exp = (32'h1 << STAT_ASLEEP_BIT) | (32'(MODE_STBY) << STAT_MODE_LSB);
		st_exp |= 32'h1 << STAT_BOD_BIT;
		nap(3'h0, 9'h1ff, 1'b1);
		nap(3'h7, 9'h1ff, 1'b1);
		nap(3'h1, 9'h0ff, 1'b0);
		i_core.raise(7);
		wake(n);
		chk("idle wake", 32'(n), 32'(WAKE_CYCLES + 2));
		chk("wake irq", 32'(wirq), 32'h1);
		nap(3'h3, 9'h05d, 1'b0);
		i_core.raise(2);
		repeat (12) @(posedge clk_i);
		chk("stby hold", 32'(halt), 32'h1);
		bus(1'b0, STAT_OFS, 32'h0, 4'h0);
		chk("status", q, st_exp);
		i_core.raise(0);
		wake(n);
		chk("stby wake", 32'(n), 32'(WAKE_CYCLES + 2));
		nap(3'h5, 9'h01b, 1'b0);
		i_core.raise(5);
		repeat (12) @(posedge clk_i);
		chk("power_down_mode hold", 32'(halt), 32'h1);
		i_core.raise(1);
		wake(n);
		chk("power_down_mode wake", 32'(n > WAKE_CYCLES + 2 && n < 40), 32'h1);
		$display("end modes");
	endtask : t_modes
	task automatic t_debug();
		@(posedge clk_i);
		gie <= 1'b0;
		stby <= 5'h0f;
		nap(3'h3, 9'h03f, 1'b0);
		i_core.raise(0);
		repeat (12) @(posedge clk_i);
		chk("no enable", 32'(halt), 32'h1);
		dbg <= 1'b1;
		wake(n);
		chk("break wake", 32'(n), 32'(WAKE_CYCLES + 2));
		chk("break irq", 32'(wirq), 32'h0);
		dbg <= 1'b0;
		gie <= 1'b1;
		$display("end debug");
	endtask : t_debug
	task automatic t_bod();
		@(posedge clk_i);
		fuse <= BOD_WAIT_CFG;
		bod_rdy <= 1'b0;
		nap(3'h1, 9'h0ff, 1'b0);
		i_core.raise(7);
		repeat (20) @(posedge clk_i);
		chk("bod hold", 32'(halt), 32'h1);
		bod_rdy <= 1'b1;
		wake(n);
		chk("bod wake", 32'(n >= 3 && n <= 4), 32'h1);
		fuse <= 2'h0;
		$display("end bod");
	endtask : t_bod
	task automatic t_reset();
		// Watchdog alone keeps the low-power oscillators running
		uses <= 2'h1;
		nap(3'h5, 9'h01b, 1'b0);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("reset halt", 32'(halt), 32'h0);
		chk("reset gates", 32'(gates), 32'h1ff);
		bus(1'b0, CTRL_OFS, 32'h0, 4'h0);
		chk("reset ctrl", q, 32'h0);
		$display("end reset");
	endtask : t_reset
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_modes();
		t_debug();
		t_bod();
		t_reset();
		report_and_stop();
	end
	// Whole sequence needs well under a thousand cycles
	initial begin
		#20000;
		mismatches++;
		report_and_stop();
	end
endmodule : sleep_ctl_unit_bench
